// >>> testbench/timer_counter_modulo_core_tb.sv
`timescale 1ns/1ps
module timer_counter_modulo_core_tb;
  import tmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic fixed_tick = 1'b0;
  logic bdm_active = 1'b0;
  logic run = 1'b0;
  logic [1:0] gpio_data = 2'h0;
  logic [1:0] gpio_dir = 2'h0;
  logic [1:0] channel_pin_in, channel_pin_out;
  logic [1:0] channel_pin_oe, channel_pullup_en;
  logic [31:0] rd, hold;
  logic err;
  int num_errors = 0;
  int n_checks = 0;

  tmc_timer_core uut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pready, .prdata, .pslverr, .irq, .fixed_tick,
    .bdm_active, .channel_pin_in, .channel_pin_out, .channel_pin_oe,
    .channel_pullup_en, .gpio_data, .gpio_dir);
  tmc_pin_model far (.pclk, .presetn, .run, .pin(channel_pin_in));

  // 125 MHz bus clock
  always #4 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  // Setup, then hold the access phase until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h0C, 32'h0);
    rchk(8'h10, 32'h0);
    chk({30'h0, channel_pin_oe}, 32'h0);
    chk({30'h0, channel_pullup_en}, 32'h0);
    xfer(1'b0, 8'h40, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    // Modulo 5 from the bus clock, overflow unmasked
    wr(8'h0C, 8'h00);
    wr(8'h10, 8'h05);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h08);
    repeat (20) @(posedge pclk);
    wr(8'h00, 8'h00);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, 8'h08, 8'h00);
    chk({31'h0, rd[7:0] <= 8'h05}, 32'h1);
    rchk(8'h14, 32'h1);
    rchk(8'h14, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test overflow done");
    // Low byte alone keeps the flag quiet; high byte re-arms it
    wr(8'h18, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h03);
    wr(8'h00, 8'h08);
    repeat (30) @(posedge pclk);
    wr(8'h00, 8'h00);
    rchk(8'h14, 32'h0);
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h08);
    repeat (30) @(posedge pclk);
    wr(8'h00, 8'h00);
    chk({31'h0, irq}, 32'h0);
    rchk(8'h14, 32'h1);
    $display("test modulo pair done");
    // Free run: coherent byte pair, then debug freeze
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h08);
    wr(8'h08, 8'h00);
    rchk(8'h04, 32'h0);
    repeat (100) @(posedge pclk);
    xfer(1'b0, 8'h08, 8'h00);
    chk({31'h0, rd[7:0] < 8'h10}, 32'h1);
    xfer(1'b0, 8'h08, 8'h00);
    chk({31'h0, rd[7:0] > 8'h64}, 32'h1);
    bdm_active <= 1'b1;
    xfer(1'b0, 8'h08, 8'h00);
    hold = rd;
    repeat (20) @(posedge pclk);
    rchk(8'h08, hold);
    bdm_active <= 1'b0;
    $display("test read latch done");
    // External clock on pin 0, channel 0 kept off the pin
    wr(8'h00, 8'h18);
    wr(8'h20, 8'h10);
    wr(8'h28, 8'h05);
    wr(8'h08, 8'h00);
    repeat (40) @(posedge pclk);
    rchk(8'h08, 32'h0);
    run <= 1'b1;
    repeat (100) @(posedge pclk);
    run <= 1'b0;
    repeat (8) @(posedge pclk);
    wr(8'h00, 8'h00);
    xfer(1'b0, 8'h08, 8'h00);
    chk({31'h0, rd[7:0] >= 8'd20 && rd[7:0] <= 8'd27}, 32'h1);
    rchk(8'h14, 32'h2);
    $display("test external clock done");
    // Pin ownership against the port logic
    gpio_dir <= 2'h3;
    gpio_data <= 2'h1;
    repeat (3) @(posedge pclk);
    chk({30'h0, channel_pin_oe}, 32'h3);
    chk({31'h0, channel_pin_out[0]}, 32'h1);
    wr(8'h30, 8'h1C);
    gpio_dir <= 2'h1;
    repeat (3) @(posedge pclk);
    chk({30'h0, channel_pin_oe}, 32'h3);
    wr(8'h30, 8'h04);
    wr(8'h1C, 8'h02);
    gpio_dir <= 2'h3;
    repeat (3) @(posedge pclk);
    chk({30'h0, channel_pin_oe}, 32'h1);
    chk({30'h0, channel_pullup_en}, 32'h2);
    wr(8'h30, 8'h00);
    repeat (3) @(posedge pclk);
    chk({30'h0, channel_pin_oe}, 32'h3);
    $display("test pins done");
    // Capture of a pin 0 rising edge while the bus clock counts
    wr(8'h20, 8'h04);
    wr(8'h00, 8'h08);
    run <= 1'b1;
    repeat (12) @(posedge pclk);
    rchk(8'h14, 32'h2);
    $display("test capture done");
    summarize();
  end
endmodule

// >>> testbench/tmc_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: external timer clock source and channel pin levels
// ----------------------------------------------------------------
module tmc_pin_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic [1:0] pin
);
  logic [1:0] div;

  // Pin 0 toggles at a quarter of the bus rate, still outside bursts
  // Pin 1 rests high, as a pulled-up idle line would
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div <= 2'h0;
      pin <= 2'h2;
    end
    else if (run)
    begin
      div <= div + 2'h1;
      pin[0] <= div[1];
    end
  end
endmodule

// >>> verilog/tmc_channel.sv
`timescale 1ns/1ps
module tmc_channel
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic [1:0] els,
  input wire logic [15:0] value,
  input wire logic [15:0] next_cnt,
  input wire logic cnt_tick,
  input wire logic ovf_tick,
  input wire logic pin_level,
  input wire logic blocked,
  output logic pin_drive,
  output logic event_hit,
  output logic capture
);
  import tmc_pkg::*;

  typedef struct packed {
    logic out;
    logic prev;
    logic [15:0] cmp;
  } tmc_ch_state_t;

  tmc_ch_state_t st;
  tmc_ch_state_t next_st;
  logic match;
  logic edge_seen;

  // Capture, compare or edge-aligned PWM per channel [R11]
  always_comb
  begin
    next_st = st;
    next_st.prev = pin_level;
    event_hit = 1'b0;
    capture = 1'b0;
    // PWM value is buffered and only taken at overflow
    if (!mode[1] || ovf_tick)
    begin
      next_st.cmp = value;
    end
    match = cnt_tick && (next_cnt == st.cmp);
    edge_seen = (els[0] && pin_level && !st.prev)
      || (els[1] && !pin_level && st.prev);
    case (mode)
      TMC_MS_CAPTURE:
      begin
        // A pin lent to the clock input is never sensed [R05]
        capture = edge_seen && !blocked;
        event_hit = capture;
      end
      TMC_MS_COMPARE:
      begin
        // Still a software timer without its pin [R05]
        event_hit = match;
        if (match)
        begin
          case (els)
            TMC_ELS_TOGGLE: next_st.out = !st.out;
            TMC_ELS_CLEAR: next_st.out = 1'b0;
            TMC_ELS_SET: next_st.out = 1'b1;
            default: next_st.out = st.out;
          endcase
        end
      end
      default:
      begin
        // High-true when the low select bit is clear
        if (ovf_tick)
        begin
          next_st.out = !els[0];
        end
        if (match)
        begin
          next_st.out = els[0];
        end
        event_hit = match;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pin_drive = st.out;

endmodule

// >>> verilog/tmc_pkg.sv
package tmc_pkg;

  // --------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------
  localparam int unsigned TMC_NCH = 2;
  localparam int unsigned TMC_AW = 8;
  localparam int unsigned TMC_DW = 32;
  localparam int unsigned TMC_PRE_W = 7;

  // --------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------
  localparam logic [7:0] TMC_OFF_SC = 8'h00;
  localparam logic [7:0] TMC_OFF_CNTH = 8'h04;
  localparam logic [7:0] TMC_OFF_CNTL = 8'h08;
  localparam logic [7:0] TMC_OFF_MODH = 8'h0C;
  localparam logic [7:0] TMC_OFF_MODL = 8'h10;
  localparam logic [7:0] TMC_OFF_STAT = 8'h14;
  localparam logic [7:0] TMC_OFF_MASK = 8'h18;
  localparam logic [7:0] TMC_OFF_PULL = 8'h1C;
  localparam logic [7:0] TMC_OFF_CH_BASE = 8'h20;
  localparam logic [7:0] TMC_OFF_CH_STRIDE = 8'h10;
  localparam logic [7:0] TMC_OFF_CH_CSC = 8'h00;
  localparam logic [7:0] TMC_OFF_CH_VH = 8'h04;
  localparam logic [7:0] TMC_OFF_CH_VL = 8'h08;

  // --------------------------------------------------------------
  // Field layout and reset values
  // --------------------------------------------------------------
  localparam int unsigned TMC_SC_CENTER_ALIGNED_PWM_SELECT = 5;
  localparam int unsigned TMC_SC_CLKS_LSB = 3;
  localparam int unsigned TMC_SC_PS_LSB = 0;
  localparam int unsigned TMC_CSC_MS_LSB = 4;
  localparam int unsigned TMC_CSC_ELS_LSB = 2;
  localparam int unsigned TMC_STAT_OVF = 0;
  localparam int unsigned TMC_STAT_CH_LSB = 1;
  localparam logic [7:0] TMC_SC_WMASK = 8'h3F;
  localparam logic [7:0] TMC_CSC_WMASK = 8'h3C;
  localparam logic [7:0] TMC_SC_RESET = 8'h00;
  localparam logic [7:0] TMC_CSC_RESET = 8'h00;
  localparam logic [15:0] TMC_MOD_RESET = 16'h0000;
  localparam logic [15:0] TMC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TMC_CNT_ONE = 16'h0001;
  localparam logic [15:0] TMC_CNT_MAX = 16'hFFFF;
  localparam logic [6:0] TMC_PRE_FULL = 7'h7F;

  // --------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    TMC_CLK_OFF = 2'h0,
    TMC_CLK_BUS = 2'h1,
    TMC_CLK_FIXED = 2'h2,
    TMC_CLK_EXT = 2'h3
  } tmc_clk_sel_t;

  localparam logic [1:0] TMC_MS_CAPTURE = 2'h0;
  localparam logic [1:0] TMC_MS_COMPARE = 2'h1;
  localparam logic [1:0] TMC_ELS_NONE = 2'h0;
  localparam logic [1:0] TMC_ELS_TOGGLE = 2'h1;
  localparam logic [1:0] TMC_ELS_CLEAR = 2'h2;
  localparam logic [1:0] TMC_ELS_SET = 2'h3;

  typedef enum logic [2:0] {
    TMC_MOD_IDLE = 3'b001,
    TMC_MOD_WAIT_LOW = 3'b010,
    TMC_MOD_WAIT_HIGH = 3'b100
  } tmc_mod_state_t;

endpackage

// >>> verilog/tmc_sync3.sv
`timescale 1ns/1ps
module tmc_sync3
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  import tmc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } tmc_sync_state_t;

  tmc_sync_state_t st;
  tmc_sync_state_t next_st;

  // Accept a new level only when the last two stages agree
  always_comb
  begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.q = st.s3; // [R02]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q = st.q;

  property p_sync_agree;
    @(posedge pclk) disable iff (!presetn)
    (st.q != $past(st.q)) |-> $past(st.s2 == st.s3);
  endproperty
  a_sync_agree: assert property (p_sync_agree) // [R02]
    else $error("sync output moved without two stages agreeing");

endmodule

// >>> verilog/tmc_timer_core.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// [R01] Select 1:1 clocks counter from external pin
// [R02] External clock synchronised to bus clock
// [R03] External clock below half bus rate
// [R04] External clock kept at quarter bus rate
// [R05] Clock-input channel releases pin, compare still works
// [R06] Software sets clock-input channel selects to zero
// [R07] No pin function returns pin to GPIO
// [R08] Timer-owned pin ignores port data, direction
// [R09] Reset: timer off, pins inputs, no pullups
// [R10] Pullup allowed on timer input pins
// [R11] Channels: capture, compare or buffered PWM
// [R12] Status, counter, modulo and channel registers
// [R13] Debug mode freezes counter and read latches
// [R14] At modulo: wrap to zero or count down
// [R15] Overflow flag set on reaching modulo
// [R16] Half-written modulo suppresses overflow flag
// [R17] Reset modulo zero means free-running counter
// [R18] Software rewrites modulo soon after overflow
// [R19] High-byte read latches coherent low byte
// ----------------------------------------------------------------
module tmc_timer_core
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [tmc_pkg::TMC_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tmc_pkg::TMC_DW-1:0] pwdata,
  output logic pready,
  output logic [tmc_pkg::TMC_DW-1:0] prdata,
  output logic pslverr,
  output logic irq,
  input wire logic fixed_tick,
  input wire logic bdm_active,
  input wire logic [tmc_pkg::TMC_NCH-1:0] channel_pin_in,
  output logic [tmc_pkg::TMC_NCH-1:0] channel_pin_out,
  output logic [tmc_pkg::TMC_NCH-1:0] channel_pin_oe,
  output logic [tmc_pkg::TMC_NCH-1:0] channel_pullup_en,
  input wire logic [tmc_pkg::TMC_NCH-1:0] gpio_data,
  input wire logic [tmc_pkg::TMC_NCH-1:0] gpio_dir
);
  import tmc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sc;
    logic [15:0] cnt;
    logic cnt_down;
    logic [TMC_PRE_W-1:0] pre;
    logic [7:0] cnt_lat;
    logic lat_valid;
    logic [15:0] modv;
    tmc_mod_state_t mod_st;
    logic [TMC_NCH:0] stat;
    logic [TMC_NCH:0] mask;
    logic [TMC_NCH-1:0] pull;
    logic [TMC_NCH-1:0][7:0] csc;
    logic [TMC_NCH-1:0][15:0] cval;
    logic ext_prev;
    logic pready;
    logic [TMC_DW-1:0] prdata;
    logic pslverr;
    logic irq;
    logic [TMC_NCH-1:0] pin_out;
    logic [TMC_NCH-1:0] pin_oe;
    logic [TMC_NCH-1:0] pull_en;
  } tmc_core_state_t;

  tmc_core_state_t st;
  tmc_core_state_t next_st;

  logic [TMC_NCH-1:0] pin_sync;
  logic [TMC_NCH-1:0] ch_drive;
  logic [TMC_NCH-1:0] ch_event;
  logic [TMC_NCH-1:0] ch_capture;
  logic [TMC_NCH-1:0] owns;
  logic [15:0] cnt_after;
  logic [TMC_DW-1:0] rd_word;
  logic src_tick;
  logic cnt_tick;
  logic at_top;
  logic ovf_tick;
  logic ext_rise;
  logic ext_sel;
  logic setup;
  logic wr_acc;
  logic [2:0] ps;
  logic [1:0] clks;
  logic [TMC_PRE_W-1:0] pmask;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] ch_addr(input int n, input logic [7:0] o);
    ch_addr = 8'(TMC_OFF_CH_BASE + TMC_OFF_CH_STRIDE * n + o);
  endfunction

  function automatic logic reg_hit(input logic [7:0] a); // [R12]
    reg_hit = (a == TMC_OFF_SC) || (a == TMC_OFF_CNTH)
      || (a == TMC_OFF_CNTL) || (a == TMC_OFF_MODH)
      || (a == TMC_OFF_MODL) || (a == TMC_OFF_STAT)
      || (a == TMC_OFF_MASK) || (a == TMC_OFF_PULL);
    for (int n = 0; n < TMC_NCH; n++)
    begin
      reg_hit = reg_hit || (a == ch_addr(n, TMC_OFF_CH_CSC))
        || (a == ch_addr(n, TMC_OFF_CH_VH))
        || (a == ch_addr(n, TMC_OFF_CH_VL));
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < TMC_NCH; g++)
    begin : g_ch
      tmc_sync3 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(channel_pin_in[g]),
        .q(pin_sync[g])
      );
      tmc_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .mode(st.csc[g][TMC_CSC_MS_LSB +: 2]),
        .els(st.csc[g][TMC_CSC_ELS_LSB +: 2]),
        .value(st.cval[g]),
        .next_cnt(cnt_after),
        .cnt_tick(cnt_tick),
        .ovf_tick(ovf_tick),
        .pin_level(pin_sync[g]),
        .blocked(g == 0 && ext_sel),
        .pin_drive(ch_drive[g]),
        .event_hit(ch_event[g]),
        .capture(ch_capture[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Counter clock source and prescaler
  // ----------------------------------------------------------------
  // Channel 0 pin doubles as the external clock input
  always_comb
  begin
    ps = st.sc[TMC_SC_PS_LSB +: 3];
    clks = st.sc[TMC_SC_CLKS_LSB +: 2];
    ext_sel = (clks == TMC_CLK_EXT);
    ext_rise = pin_sync[0] && !st.ext_prev; // [R02]
    case (clks)
      TMC_CLK_BUS: src_tick = 1'b1;
      TMC_CLK_FIXED: src_tick = fixed_tick;
      TMC_CLK_EXT: src_tick = ext_rise; // [R01]
      default: src_tick = 1'b0; // Off after reset [R09]
    endcase
    pmask = TMC_PRE_FULL >> (3'h7 - ps);
    // Debug mode stops the count entirely [R13]
    cnt_tick = src_tick && !bdm_active && ((st.pre & pmask) == pmask);
    // Zero modulo means wrap at the full 16-bit range [R17]
    at_top = (st.modv == TMC_MOD_RESET) ? (st.cnt == TMC_CNT_MAX)
      : (st.cnt == st.modv);
    ovf_tick = cnt_tick && at_top && !st.cnt_down;
    if (!st.cnt_down)
    begin
      cnt_after = at_top ? TMC_CNT_ZERO : 16'(st.cnt + TMC_CNT_ONE);
    end
    else
    begin
      cnt_after = 16'(st.cnt - TMC_CNT_ONE);
    end
    // Up-down mode with a nonzero modulo turns round instead of wrapping [R14]
    if (ovf_tick && st.sc[TMC_SC_CENTER_ALIGNED_PWM_SELECT] && st.modv != TMC_MOD_RESET)
    begin
      cnt_after = 16'(st.cnt - TMC_CNT_ONE);
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int n = 0; n < TMC_NCH; n++)
    begin
      // No edge/level select means no pin function [R07]
      owns[n] = (st.csc[n][TMC_CSC_ELS_LSB +: 2] != TMC_ELS_NONE)
        && !(n == 0 && ext_sel); // [R05]
    end
  end

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = '0;
    case (paddr)
      TMC_OFF_SC: rd_word[7:0] = st.sc;
      TMC_OFF_CNTH: rd_word[7:0] = st.cnt[15:8];
      TMC_OFF_CNTL: rd_word[7:0] = st.lat_valid ? st.cnt_lat
        : st.cnt[7:0]; // [R19]
      TMC_OFF_MODH: rd_word[7:0] = st.modv[15:8];
      TMC_OFF_MODL: rd_word[7:0] = st.modv[7:0];
      TMC_OFF_STAT: rd_word[TMC_NCH:0] = st.stat;
      TMC_OFF_MASK: rd_word[TMC_NCH:0] = st.mask;
      TMC_OFF_PULL: rd_word[TMC_NCH-1:0] = st.pull;
      default: rd_word = '0;
    endcase
    for (int n = 0; n < TMC_NCH; n++)
    begin
      if (paddr == ch_addr(n, TMC_OFF_CH_CSC))
        rd_word[7:0] = st.csc[n];
      if (paddr == ch_addr(n, TMC_OFF_CH_VH))
        rd_word[7:0] = st.cval[n][15:8];
      if (paddr == ch_addr(n, TMC_OFF_CH_VL))
        rd_word[7:0] = st.cval[n][7:0];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Order matters: writes, then read clears, then event sets
  always_comb
  begin
    next_st = st;
    setup = psel && !penable;
    wr_acc = psel && penable && st.pready && pwrite;
    next_st.ext_prev = pin_sync[0];
    if (src_tick && !bdm_active)
    begin
      next_st.pre = TMC_PRE_W'(st.pre + 1'b1);
    end
    if (cnt_tick)
    begin
      next_st.cnt = cnt_after; // [R14]
      if (ovf_tick && st.sc[TMC_SC_CENTER_ALIGNED_PWM_SELECT] && st.modv != TMC_MOD_RESET)
      begin
        next_st.cnt_down = 1'b1; // [R14]
      end
      else if (st.cnt_down && st.cnt == TMC_CNT_ONE)
      begin
        next_st.cnt_down = 1'b0;
      end
    end
    // Zero-wait slave: answer raised for the access phase
    next_st.pready = setup;
    next_st.pslverr = setup && !reg_hit(paddr);
    if (wr_acc)
    begin
      case (paddr)
        TMC_OFF_SC: next_st.sc = pwdata[7:0] & TMC_SC_WMASK;
        TMC_OFF_CNTH, TMC_OFF_CNTL:
        begin
          // Any counter write restarts count and prescaler
          next_st.cnt = TMC_CNT_ZERO;
          next_st.pre = '0;
          next_st.cnt_down = 1'b0;
          next_st.lat_valid = 1'b0;
        end
        TMC_OFF_MODH:
        begin
          next_st.modv[15:8] = pwdata[7:0];
          next_st.mod_st = (st.mod_st == TMC_MOD_WAIT_HIGH)
            ? TMC_MOD_IDLE : TMC_MOD_WAIT_LOW; // [R16]
        end
        TMC_OFF_MODL:
        begin
          next_st.modv[7:0] = pwdata[7:0];
          next_st.mod_st = (st.mod_st == TMC_MOD_WAIT_LOW)
            ? TMC_MOD_IDLE : TMC_MOD_WAIT_HIGH; // [R16]
        end
        TMC_OFF_MASK: next_st.mask = pwdata[TMC_NCH:0];
        TMC_OFF_PULL: next_st.pull = pwdata[TMC_NCH-1:0];
        default: next_st.sc = st.sc;
      endcase
      for (int n = 0; n < TMC_NCH; n++)
      begin
        if (paddr == ch_addr(n, TMC_OFF_CH_CSC))
          next_st.csc[n] = pwdata[7:0] & TMC_CSC_WMASK; // [R11]
        if (paddr == ch_addr(n, TMC_OFF_CH_VH))
          next_st.cval[n][15:8] = pwdata[7:0];
        if (paddr == ch_addr(n, TMC_OFF_CH_VL))
          next_st.cval[n][7:0] = pwdata[7:0];
      end
    end
    if (setup && !pwrite)
    begin
      next_st.prdata = rd_word;
      if (paddr == TMC_OFF_STAT)
        next_st.stat = '0;
      // Latches hold still while debug mode is active [R13]
      if (paddr == TMC_OFF_CNTH && !bdm_active)
      begin
        next_st.cnt_lat = st.cnt[7:0]; // [R19]
        next_st.lat_valid = 1'b1;
      end
      if (paddr == TMC_OFF_CNTL && !bdm_active)
        next_st.lat_valid = 1'b0;
    end
    // Flag sets win over a same-cycle read clear
    if (ovf_tick && st.mod_st == TMC_MOD_IDLE)
      next_st.stat[TMC_STAT_OVF] = 1'b1; // [R15] [R16]
    for (int n = 0; n < TMC_NCH; n++)
    begin
      if (ch_event[n])
        next_st.stat[TMC_STAT_CH_LSB + n] = 1'b1;
      if (ch_capture[n])
        next_st.cval[n] = st.cnt;
      // Port controls only steer pins the timer does not own [R08]
      next_st.pin_oe[n] = owns[n]
        ? (st.csc[n][TMC_CSC_MS_LSB +: 2] != TMC_MS_CAPTURE)
        : gpio_dir[n];
      next_st.pin_out[n] = owns[n] ? ch_drive[n] : gpio_data[n];
      next_st.pull_en[n] = owns[n] && st.pull[n]
        && (st.csc[n][TMC_CSC_MS_LSB +: 2] == TMC_MS_CAPTURE); // [R10]
    end
    next_st.irq = |(next_st.stat & next_st.mask);
  end

  // Everything clears to the disabled, all-input state [R09] [R17]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.mod_st <= TMC_MOD_IDLE;
      st.modv <= TMC_MOD_RESET;
      st.sc <= TMC_SC_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign channel_pin_out = st.pin_out;
  assign channel_pin_oe = st.pin_oe;
  assign channel_pullup_en = st.pull_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ext_clock;
    (ext_sel && !wr_acc && !(pin_sync[0] && !st.ext_prev))
      |=> $stable(st.cnt);
  endproperty
  a_ext_clock: assert property (p_ext_clock) // [R01]
    else $error("external clock mode ticked without a pin edge");

  property p_freeze;
    (bdm_active && !wr_acc) |=> (st.cnt == $past(st.cnt));
  endproperty
  a_freeze: assert property (p_freeze) // [R13]
    else $error("counter moved during debug mode");

  property p_wrap;
    (cnt_tick && at_top && !st.cnt_down && !st.sc[TMC_SC_CENTER_ALIGNED_PWM_SELECT]
      && !wr_acc) |=> (st.cnt == TMC_CNT_ZERO);
  endproperty
  a_wrap: assert property (p_wrap) // [R14]
    else $error("counter did not wrap at modulo");

  property p_reverse;
    (cnt_tick && at_top && !st.cnt_down && st.sc[TMC_SC_CENTER_ALIGNED_PWM_SELECT]
      && st.modv != TMC_MOD_RESET && !wr_acc) |=> st.cnt_down;
  endproperty
  a_reverse: assert property (p_reverse) // [R14]
    else $error("center-aligned counter did not reverse");

  property p_ovf_set;
    (ovf_tick && st.mod_st == TMC_MOD_IDLE) |=> st.stat[TMC_STAT_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) // [R15]
    else $error("overflow flag not set at modulo");

  property p_mod_inhibit;
    (st.mod_st != TMC_MOD_IDLE && !st.stat[TMC_STAT_OVF])
      |=> !st.stat[TMC_STAT_OVF];
  endproperty
  a_mod_inhibit: assert property (p_mod_inhibit) // [R16]
    else $error("overflow flagged during half-written modulo");

  property p_free_run;
    (cnt_tick && st.modv == TMC_MOD_RESET && st.cnt == TMC_CNT_MAX
      && !wr_acc) |=> (st.cnt == TMC_CNT_ZERO);
  endproperty
  a_free_run: assert property (p_free_run) // [R17]
    else $error("free-running counter did not wrap at full range");

  property p_gpio_pin;
    !owns[1] |=> (channel_pin_oe[1] == $past(gpio_dir[1])
      && channel_pin_out[1] == $past(gpio_data[1]));
  endproperty
  a_gpio_pin: assert property (p_gpio_pin) // [R07]
    else $error("released pin not under port control");

  property p_ext_release;
    ext_sel |=> (channel_pin_oe[0] == $past(gpio_dir[0]));
  endproperty
  a_ext_release: assert property (p_ext_release) // [R05]
    else $error("clock input pin still driven by channel");

  property p_latch;
    (setup && !pwrite && paddr == TMC_OFF_CNTH && !bdm_active)
      |=> (st.lat_valid && st.cnt_lat == $past(st.cnt[7:0]));
  endproperty
  a_latch: assert property (p_latch) // [R19]
    else $error("low byte not latched on high-byte read");

  c_overflow: cover property (ovf_tick && st.mod_st == TMC_MOD_IDLE);
  c_ext_count: cover property (ext_sel && cnt_tick);
  c_capture: cover property (|ch_capture);
  c_irq: cover property (irq);

endmodule
